// file: src/lcsc_ctrl.sv
/*
  led converter switch control: low-side gate, dimming gate, faults, hiccup.
  assumes comparator inputs are synchronous digital levels; srst_i is the
  supply undervoltage lockout.
*/
`timescale 1ns/1ps
`include "lcsc_regs.svh"

// Operation
// - no low-side switching while supply is under lockout threshold
// - switching begins when dimming input goes high
// - oscillator runs at low or high nominal frequency per build
// - oscillator restarts on dimming rising edge, first pulse aligned
// - current-limit trip ends the gate pulse for that cycle
// - pwm comparator trip ends pulse until the next oscillator cycle
// - dimming gate active while dimming input high, inactive when low
// - any fault forces dimming gate inactive
// - spread spectrum: triangular dither down then up over equal spans
// - comparators ignored during leading-edge blanking
// - overvoltage stops switching and forces dimming gate inactive
// - after overvoltage clears, resume only if dimming input high
// - short flagged only when headroom and current both tripped
// - short stops switching and forces dimming gate inactive
// - after short, hiccup timer of oscillator clocks before restart
// - dimming is pwm after three edges in range, else ramp compare
// - overtemperature stops switching until indication clears
module lcsc_ctrl
(
  input wire logic sys_clk_i,
  input wire logic srst_i,
  input wire logic hi_freq_i,
  input wire logic ss_en_i,
  input wire logic dim_pulse_in_i,
  input wire logic dim_level_above_ramp_i,
  input wire logic current_limit_trip_i,
  input wire logic pwm_comp_trip_i,
  input wire logic overvoltage_sense_i,
  input wire logic short_headroom_low_i,
  input wire logic short_current_high_i,
  input wire logic overtemp_i,
  output logic low_side_gate_out_o,
  output logic dim_switch_gate_out_o,
  output logic pwm_mode_o,
  output logic short_fault_o
);

  // ----------------------------------------
  // dimming source selection
  // ----------------------------------------
  logic dim_prev_reg;
  logic dim_prev_next;
  logic [1:0] edges_reg;
  logic [1:0] edges_next;
  logic [19:0] gap_reg;
  logic [19:0] gap_next;
  logic pwm_mode_reg;
  logic pwm_mode_next;
  logic dim_eff;

  // the compare against the internal ramp is analog; its result arrives
  // on dim_level_above_ramp_i
  always_comb
  begin
    dim_prev_next = dim_pulse_in_i;
    edges_next = edges_reg;
    gap_next = gap_reg;
    pwm_mode_next = pwm_mode_reg;
    if (dim_pulse_in_i != dim_prev_reg)
    begin
      gap_next = 20'h00000;
      if (edges_reg == 2'(`LCSC_DIM_EDGES - 1))
        pwm_mode_next = 1'b1;
      else
        edges_next = edges_reg + 2'h1;
    end
    else if (gap_reg >= 20'(`LCSC_DIM_EDGE_MAX))
    begin
      edges_next = 2'h0;
      pwm_mode_next = 1'b0;
    end
    else
    begin
      gap_next = gap_reg + 20'h00001;
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
    begin
      dim_prev_reg <= 1'b0;
      edges_reg <= 2'h0;
      gap_reg <= 20'h00000;
      pwm_mode_reg <= 1'b0;
    end
    else
    begin
      dim_prev_reg <= dim_prev_next;
      edges_reg <= edges_next;
      gap_reg <= gap_next;
      pwm_mode_reg <= pwm_mode_next;
    end
  end

  assign dim_eff = pwm_mode_reg ? dim_pulse_in_i : dim_level_above_ramp_i;

  // ----------------------------------------
  // faults and hiccup
  // ----------------------------------------
  logic dim_eff_prev_reg;
  logic short_reg;
  logic short_next;
  logic [13:0] hiccup_reg;
  logic [13:0] hiccup_next;
  logic fault;
  logic osc_start;
  logic dim_rise;

  assign dim_rise = dim_eff && !dim_eff_prev_reg;
  // ov and overtemperature are comparators with their own hysteresis, so
  // the fault simply follows them
  assign fault = overvoltage_sense_i || overtemp_i || short_reg;

  always_comb
  begin
    short_next = short_reg;
    hiccup_next = hiccup_reg;
    if (short_headroom_low_i && short_current_high_i)
    begin
      short_next = 1'b1;
      hiccup_next = 14'h0000;
    end
    else if (short_reg && osc_start)
    begin
      if (hiccup_reg == 14'(`LCSC_HICCUP_CLKS - 1))
        short_next = 1'b0;
      else
        hiccup_next = hiccup_reg + 14'h0001;
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
    begin
      dim_eff_prev_reg <= 1'b0;
      short_reg <= 1'b0;
      hiccup_reg <= 14'h0000;
    end
    else
    begin
      dim_eff_prev_reg <= dim_eff;
      short_reg <= short_next;
      hiccup_reg <= hiccup_next;
    end
  end

  // oscillator keeps running during hiccup so the timer counts its clocks
  lcsc_osc u_osc
  (
    .sys_clk_i(sys_clk_i),
    .srst_i(srst_i),
    .run_i(dim_eff || short_reg),
    .sync_i(dim_rise),
    .hi_freq_i(hi_freq_i),
    .ss_en_i(ss_en_i),
    .start_o(osc_start)
  );

  // ----------------------------------------
  // switch state machine
  // ----------------------------------------
  lcsc_pkg::lcsc_sw_state_t sw_reg;
  lcsc_pkg::lcsc_sw_state_t sw_next;
  logic [1:0] blank_reg;
  logic [1:0] blank_next;
  logic gate_reg;
  logic gate_next;
  logic dimgate_reg;
  logic dimgate_next;
  logic trip;

  assign trip = current_limit_trip_i || pwm_comp_trip_i;

  always_comb
  begin
    sw_next = sw_reg;
    blank_next = blank_reg;
    case (sw_reg)
      lcsc_pkg::LCSC_SW_OFF:
        if (fault)
          sw_next = lcsc_pkg::LCSC_SW_HALT;
        else if (dim_eff && (dim_rise || osc_start))
        begin
          sw_next = lcsc_pkg::LCSC_SW_ON;
          blank_next = 2'(`LCSC_BLANK_CYC);
        end
      lcsc_pkg::LCSC_SW_ON:
        if (fault || !dim_eff)
          sw_next = lcsc_pkg::LCSC_SW_OFF;
        else if (osc_start)
          blank_next = 2'(`LCSC_BLANK_CYC);
        else if (blank_reg != 2'h0)
          blank_next = blank_reg - 2'h1;
        else if (trip)
          sw_next = lcsc_pkg::LCSC_SW_WAIT;
      lcsc_pkg::LCSC_SW_WAIT:
        if (fault || !dim_eff)
          sw_next = lcsc_pkg::LCSC_SW_OFF;
        else if (osc_start)
        begin
          sw_next = lcsc_pkg::LCSC_SW_ON;
          blank_next = 2'(`LCSC_BLANK_CYC);
        end
      lcsc_pkg::LCSC_SW_HALT:
        if (!fault)
          sw_next = lcsc_pkg::LCSC_SW_OFF;
      default:
        sw_next = lcsc_pkg::LCSC_SW_OFF;
    endcase
    gate_next = (sw_next == lcsc_pkg::LCSC_SW_ON);
    dimgate_next = dim_eff && !fault;
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
    begin
      sw_reg <= lcsc_pkg::LCSC_SW_OFF;
      blank_reg <= 2'h0;
      gate_reg <= 1'b0;
      dimgate_reg <= 1'b0;
    end
    else
    begin
      sw_reg <= sw_next;
      blank_reg <= blank_next;
      gate_reg <= gate_next;
      dimgate_reg <= dimgate_next;
    end
  end

  assign low_side_gate_out_o = gate_reg;
  assign dim_switch_gate_out_o = dimgate_reg;
  assign pwm_mode_o = pwm_mode_reg;
  assign short_fault_o = short_reg;

  // ----------------------------------------
  // checks
  // ----------------------------------------
  sequence s_short_seen;
    short_headroom_low_i && short_current_high_i;
  endsequence

  AST_RESET_QUIET: assert property (@(posedge sys_clk_i) srst_i |=> !low_side_gate_out_o && !dim_switch_gate_out_o)
    else $error("outputs active after lockout");
  AST_RISE_STARTS: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    (dim_rise && !fault && sw_reg == lcsc_pkg::LCSC_SW_OFF) |=> low_side_gate_out_o)
    else $error("no gate pulse on dimming rise");
  AST_BLANKING: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    $rose(low_side_gate_out_o) && !fault |=> low_side_gate_out_o || fault || !dim_eff)
    else $error("pulse ended inside blanking");
  AST_TRIP_OFF: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    (sw_reg == lcsc_pkg::LCSC_SW_ON && blank_reg == 2'h0 && trip && !osc_start) |=> !low_side_gate_out_o)
    else $error("gate still on after trip");
  AST_DIM_FOLLOW: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    1'b1 |=> dim_switch_gate_out_o == ($past(dim_eff) && !$past(fault)))
    else $error("dimming gate mismatch");
  AST_FAULT_ISOLATE: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    fault |=> !dim_switch_gate_out_o && !low_side_gate_out_o)
    else $error("fault did not isolate");
  AST_SHORT_LATCH: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    s_short_seen |=> short_fault_o)
    else $error("short not flagged");
  AST_SHORT_NEEDS_BOTH: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    !short_fault_o && !(short_headroom_low_i && short_current_high_i) |=> !short_fault_o)
    else $error("short flagged without both conditions");
  AST_DIM_LOW_GATE: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    !dim_eff |=> !low_side_gate_out_o)
    else $error("gate on with dimming low");

endmodule : lcsc_ctrl

// file: src/lcsc_osc.sv
/*
  dithered switching oscillator: emits a one-cycle cycle-start pulse.
  assumes sync_i pulses on the dimming rising edge; hi_freq_i is static.
*/
`timescale 1ns/1ps
`include "lcsc_regs.svh"

module lcsc_osc
(
  input wire logic sys_clk_i,
  input wire logic srst_i,
  input wire logic run_i,
  input wire logic sync_i,
  input wire logic hi_freq_i,
  input wire logic ss_en_i,
  output logic start_o
);

  logic [6:0] cnt_reg;
  logic [6:0] cnt_next;
  logic [9:0] phase_reg;
  logic [9:0] phase_next;
  logic start_reg;
  logic start_next;
  logic [6:0] per;

  // triangle offset scaled by the dither percent over one quarter span
  function automatic logic [6:0] lcsc_period(input logic hi, input logic ss, input logic [9:0] ph);
    logic [31:0] base;
    logic [31:0] tri_pos;
    logic [31:0] dev;
    base = hi ? 32'(`LCSC_PER_HI) : 32'(`LCSC_PER_LO);
    tri_pos = (32'(ph % 10'd418) < 32'd209) ? 32'(ph % 10'd418) : 32'd418 - 32'(ph % 10'd418);
    dev = (base * `LCSC_DITHER_PCT * tri_pos) / (100 * 209);
    if (!ss)
      lcsc_period = 7'(base);
    else if (ph < 10'(`LCSC_DITHER_SPAN))
      lcsc_period = 7'(base + dev); // slower: longer period
    else
      lcsc_period = 7'(base - dev);
  endfunction : lcsc_period

  assign per = lcsc_period(hi_freq_i, ss_en_i, phase_reg);

  always_comb
  begin
    cnt_next = cnt_reg;
    phase_next = phase_reg;
    start_next = 1'b0;
    if (!run_i)
    begin
      cnt_next = 7'h00;
    end
    else if (sync_i || cnt_reg >= per - 7'h01)
    begin
      // the gate rises with a sync, so that edge is already the first clock;
      // without this the first cycle after a dimming edge runs one clock long
      cnt_next = sync_i ? 7'h01 : 7'h00;
      start_next = 1'b1;
      if (!sync_i)
        phase_next = (phase_reg == 10'(2 * `LCSC_DITHER_SPAN - 1)) ? 10'h000 : phase_reg + 10'h001;
    end
    else
    begin
      cnt_next = cnt_reg + 7'h01;
    end
  end

  always_ff @(posedge sys_clk_i)
  begin
    if (srst_i)
    begin
      cnt_reg <= 7'h00;
      phase_reg <= 10'h000;
      start_reg <= 1'b0;
    end
    else
    begin
      cnt_reg <= cnt_next;
      phase_reg <= phase_next;
      start_reg <= start_next;
    end
  end

  assign start_o = start_reg;

  AST_SYNC_START: assert property (@(posedge sys_clk_i) disable iff (srst_i) run_i && sync_i |=> start_o)
    else $error("sync did not start a cycle");
  AST_PERIOD_MIN: assert property (@(posedge sys_clk_i) disable iff (srst_i)
    start_o ##1 (run_i && !sync_i)[*8] |-> !start_o)
    else $error("oscillator period too short");

endmodule : lcsc_osc

// file: src/lcsc_pkg.sv
/*
  types for the led converter switch control block.
  assumes nothing of its surroundings.
*/
package lcsc_pkg;

  // gray coded along off -> on -> wait -> halt -> off
  typedef enum logic [1:0]
  {
    LCSC_SW_OFF  = 2'b00,
    LCSC_SW_ON   = 2'b01,
    LCSC_SW_WAIT = 2'b11,
    LCSC_SW_HALT = 2'b10
  } lcsc_sw_state_t;

endpackage : lcsc_pkg

// file: src/lcsc_regs.svh
/*
  timing and count constants for the led converter switch control block.
  assumes a 25 MHz system clock (40 ns period); included by bare name.
*/
`ifndef LCSC_REGS_SVH
`define LCSC_REGS_SVH

// ----------------------------------------
// clock
// ----------------------------------------
`define LCSC_CLK_HZ 25000000
`define LCSC_CLK_PS 40000

// ----------------------------------------
// oscillator, nominal frequencies in hz
// ----------------------------------------
`define LCSC_FOSC_LO_HZ 350000
`define LCSC_FOSC_HI_HZ 2200000
`define LCSC_PER_LO (`LCSC_CLK_HZ / `LCSC_FOSC_LO_HZ)
`define LCSC_PER_HI (`LCSC_CLK_HZ / `LCSC_FOSC_HI_HZ)

// ----------------------------------------
// dither: percent and half-span in oscillator clocks
// ----------------------------------------
`define LCSC_DITHER_PCT 6
`define LCSC_DITHER_SPAN 418

// ----------------------------------------
// leading-edge blanking, least time, rounded up
// ----------------------------------------
`define LCSC_BLANK_PS 66000
`define LCSC_BLANK_CYC ((`LCSC_BLANK_PS + `LCSC_CLK_PS - 1) / `LCSC_CLK_PS)

// ----------------------------------------
// hiccup timer in oscillator clocks
// ----------------------------------------
`define LCSC_HICCUP_CLKS 8192

// ----------------------------------------
// dimming pulse detector
// ----------------------------------------
`define LCSC_DIM_EDGES 3
`define LCSC_DIM_MIN_HZ 60
`define LCSC_DIM_RAMP_HZ 200
`define LCSC_DIM_EDGE_MAX (`LCSC_CLK_HZ / `LCSC_DIM_MIN_HZ)
`define LCSC_DIM_RAMP_PER (`LCSC_CLK_HZ / `LCSC_DIM_RAMP_HZ)

`endif

// file: verif/lcsc_sw_model.sv
/*
  switch and comparator model: inductor current ramps while the low-side
  gate is on, and each comparator trips when the ramp reaches its limit.
  assumes the bench sets both limits; 8'hFF keeps the comparator quiet until the ramp reaches 8'hFF.
*/
`timescale 1ns/1ps

module lcsc_sw_model
(
  input wire logic sys_clk_i,
  input wire logic srst_i,
  input wire logic gate_i,
  input wire logic [7:0] cl_at_i,
  input wire logic [7:0] pwm_at_i,
  output logic current_limit_trip_o,
  output logic pwm_comp_trip_o
);
  // ----------------------------------------
  // switch current ramp
  // ----------------------------------------
  logic [7:0] ramp_reg;
  logic [7:0] ramp_next;

  always_comb
  begin
    ramp_next = gate_i ? ramp_reg + 8'h01 : 8'h00;
  end

  always_ff @(posedge sys_clk_i)
  begin
    ramp_reg <= srst_i ? 8'h00 : ramp_next;
  end

  // current collapses with the gate, so a trip never outlives its pulse
  assign current_limit_trip_o = gate_i && (ramp_reg >= cl_at_i);
  assign pwm_comp_trip_o = gate_i && (ramp_reg >= pwm_at_i);
endmodule : lcsc_sw_model

// file: verif/tb_top.sv
/*
  self-checking bench for the switch control block, 2.2 MHz build, with a
  closing 350 kHz run so that the dither is large enough to be seen.
  assumes the switch model above and the timing constants header.
*/
`timescale 1ns/1ps
`include "lcsc_regs.svh"

module tb_top;
  // ----------------------------------------
  // stimulus and wiring
  // ----------------------------------------
  localparam int PER = `LCSC_PER_HI;
  localparam int HICCUP = `LCSC_HICCUP_CLKS * PER;
  localparam int PER_LO = `LCSC_PER_LO;
  localparam int PER_LO_MAX = PER_LO + PER_LO * `LCSC_DITHER_PCT / 100;
  logic sys_clk_i = 1'b0;
  logic srst_i = 1'b1;
  logic hf = 1'b1;
  logic ss = 1'b0, dim = 1'b0, ramp = 1'b0, ov = 1'b0, hr = 1'b0, sc = 1'b0, ot = 1'b0;
  logic [7:0] cl_at = 8'hFF;
  logic [7:0] pwm_at = 8'hFF;
  logic clt, pwt, gate, dg, pm, sf;
  int bad_count = 0;
  int samples_checked = 0;
  int n, w, l, h;

  always #20 sys_clk_i = ~sys_clk_i;

  lcsc_ctrl u_dut
  (
    .sys_clk_i(sys_clk_i), .srst_i(srst_i), .hi_freq_i(hf), .ss_en_i(ss),
    .dim_pulse_in_i(dim), .dim_level_above_ramp_i(ramp), .current_limit_trip_i(clt),
    .pwm_comp_trip_i(pwt), .overvoltage_sense_i(ov), .short_headroom_low_i(hr),
    .short_current_high_i(sc), .overtemp_i(ot), .low_side_gate_out_o(gate),
    .dim_switch_gate_out_o(dg), .pwm_mode_o(pm), .short_fault_o(sf)
  );

  lcsc_sw_model u_sw
  (
    .sys_clk_i(sys_clk_i), .srst_i(srst_i), .gate_i(gate), .cl_at_i(cl_at),
    .pwm_at_i(pwm_at), .current_limit_trip_o(clt), .pwm_comp_trip_o(pwt)
  );

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  task automatic tick(input int k);
    repeat (k) @(posedge sys_clk_i);
    #1;
  endtask : tick

  task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
    samples_checked++;
    if (seen !== exp)
    begin
      bad_count++;
      $display("CHECK FAILED t=%0t %s", $time, msg);
    end
  endtask : chk

  task automatic wait_gate(input logic lvl, input int lim, output int k);
    k = 0;
    while (gate !== lvl && k < lim)
    begin
      tick(1);
      k++;
    end
  endtask : wait_gate

  // counts cycles in which the low-side gate is not low
  task automatic hold_low(input int k, output int hits);
    hits = 0;
    repeat (k)
    begin
      tick(1);
      if (gate !== 1'b0)
        hits++;
    end
  endtask : hold_low

  // width and off time of one whole pulse, starting from a rising gate
  task automatic pulse(output int wd, output int lo);
    int k;
    wait_gate(1'b0, 2 * PER_LO, k);
    wait_gate(1'b1, 2 * PER_LO, k);
    wait_gate(1'b0, 2 * PER_LO, wd);
    wait_gate(1'b1, 2 * PER_LO, lo);
  endtask : pulse

  task automatic results;
    $display("mismatches %0d, checks %0d", bad_count, samples_checked);
    if (bad_count == 0 && samples_checked > 0)
      $display("Test passed");
    else
      $display("Test failed");
    $finish;
  endtask : results

  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic t_dim_modes;
    ramp = 1'b1;
    tick(2);
    chk(dg, 1'b1, "ramp compare should enable dimming gate");
    chk(pm, 1'b0, "pwm mode before any edge");
    wait_gate(1'b1, 2 * PER, n);
    chk(n < 2 * PER, 1'b1, "no switching with dimming on");
    ramp = 1'b0;
    tick(2);
    chk(dg, 1'b0, "dimming gate should follow dimming off");
    hold_low(2 * PER, h);
    chk(h, 0, "gate pulsed while dimmed off");
    repeat (2)
    begin
      dim = 1'b1;
      tick(20);
      dim = 1'b0;
      tick(20);
    end
    chk(pm, 1'b1, "pwm mode not taken after edges");
    dim = 1'b1;
    wait_gate(1'b1, 4, n);
    chk(n, 1, "first pulse not aligned to dimming edge");
    chk(dg, 1'b1, "dimming gate off with dimming on");
  endtask : t_dim_modes

  task automatic t_trip(input logic [7:0] c, input logic [7:0] p, input int lo, input int hi);
    cl_at = c;
    pwm_at = p;
    pulse(w, l);
    chk(w >= lo && w <= hi, 1'b1, "pulse width after trip");
    chk(w + l, PER, "switching period");
    cl_at = 8'hFF;
    pwm_at = 8'hFF;
  endtask : t_trip

  task automatic t_fault(input logic sel);
    if (sel) ot = 1'b1; else ov = 1'b1;
    tick(2);
    chk(dg, 1'b0, "dimming gate on during fault");
    hold_low(3 * PER, h);
    chk(h, 0, "gate pulsed during fault");
    if (sel) ot = 1'b0; else ov = 1'b0;
    tick(2);
    chk(dg, 1'b1, "dimming gate did not return");
    wait_gate(1'b1, PER + 2, n);
    chk(n <= PER + 1, 1'b1, "switching did not resume");
    if (sel) ot = 1'b1; else ov = 1'b1;
    dim = 1'b0;
    tick(2);
    if (sel) ot = 1'b0; else ov = 1'b0;
    hold_low(2 * PER, h);
    chk(h, 0, "resumed with dimming off");
    chk(dg, 1'b0, "dimming gate on with dimming off");
    dim = 1'b1;
    tick(2);
  endtask : t_fault

  // the gate stands on here, as both trip levels are quiet
  task automatic t_short;
    hr = 1'b1;
    tick(3);
    chk(sf, 1'b0, "short from headroom alone");
    chk(gate, 1'b1, "switching stopped on headroom alone");
    hr = 1'b0;
    sc = 1'b1;
    tick(3);
    chk(sf, 1'b0, "short from current alone");
    chk(dg, 1'b1, "dimming gate dropped on current alone");
    hr = 1'b1;
    tick(2);
    chk(sf, 1'b1, "short not flagged");
    chk(dg, 1'b0, "dimming gate on during short");
    hr = 1'b0;
    sc = 1'b0;
    hold_low(HICCUP - 100 * PER, h);
    chk(h, 0, "restart before hiccup expired");
    chk(sf, 1'b1, "hiccup ended early");
    wait_gate(1'b1, 200 * PER, n);
    chk(n < 200 * PER, 1'b1, "no restart after hiccup");
    chk(sf, 1'b0, "short flag stuck");
  endtask : t_short

  task automatic t_lockout;
    hr = 1'b1;
    sc = 1'b1;
    tick(3);
    srst_i = 1'b1;
    tick(2);
    chk({gate, dg, pm, sf}, 4'h0, "state kept under lockout");
    hr = 1'b0;
    sc = 1'b0;
    srst_i = 1'b0;
    tick(2);
    chk(sf, 1'b0, "short survived lockout");
  endtask : t_lockout

  // at 2.2 MHz the dither is below one clock, so it is watched at 350 kHz;
  // the oscillator is idle here, so the strap may change
  task automatic t_spread;
    int mx;
    mx = 0;
    hf = 1'b0;
    ss = 1'b1;
    ramp = 1'b1;
    pwm_at = 8'h00;
    repeat (30)
    begin
      pulse(w, l);
      chk(w + l >= PER_LO && w + l <= PER_LO_MAX, 1'b1, "dithered period out of range");
      if (w + l > mx)
        mx = w + l;
    end
    chk(mx > PER_LO, 1'b1, "no slowdown in first dither half");
  endtask : t_spread

  // ----------------------------------------
  // main sequence and watchdog
  // ----------------------------------------
  initial
  begin
    tick(5);
    chk({gate, dg, pm, sf}, 4'h0, "outputs active in lockout");
    tick(1);
    srst_i = 1'b0;
    tick(1);
    t_dim_modes();
    t_trip(8'hFF, 8'h00, 3, 4);
    t_trip(8'hFF, 8'h06, 7, 8);
    t_trip(8'h06, 8'hFF, 7, 8);
    t_trip(8'h00, 8'hFF, 3, 4);
    dim = 1'b0;
    tick(2);
    chk(dg, 1'b0, "dimming gate on with dimming off");
    hold_low(3 * PER, h);
    chk(h, 0, "gate pulsed with dimming off");
    dim = 1'b1;
    tick(2);
    t_fault(1'b0);
    t_fault(1'b1);
    t_short();
    t_lockout();
    t_spread();
    results();
  end

  initial
  begin
    // the hiccup wait dominates; the rest of the run is a few thousand cycles
    #((HICCUP + 8000) * 40);
    bad_count++;
    results();
  end
endmodule : tb_top
